// ### hw/serial_port_map.svh
// register offsets, field positions, write masks and counts of the slave serial port
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// byte addresses, one aligned word each
`define OFS_TX_STATUS 8'h00
`define OFS_RX_STATUS 8'h04
`define OFS_BAUD_CTRL 8'h08
`define OFS_DIV_LOW 8'h0C
`define OFS_DIV_HIGH 8'h10
`define OFS_TX_DATA 8'h14
`define OFS_RX_DATA 8'h18
`define OFS_IRQ_EN 8'h1C
`define OFS_IRQ_FLAG 8'h20

// tx_status_control fields
`define TX_CLOCK_SOURCE_MASTER 3'h7
`define TX_TX9 3'h6
`define TX_TRANSMIT_ENABLE 3'h5
`define TX_SYNC 3'h4
`define TX_TRMT 3'h1
`define TX_TRANSMIT_NINTH_BIT 3'h0
`define TX_WMASK 8'hFD

// rx_status_control fields
`define RX_SERIAL_PORT_ENABLE 3'h7
`define RX_RX9 3'h6
`define RX_SINGLE_RECEIVE_ENABLE 3'h5
`define RX_CONTINUOUS_RECEIVE_ENABLE 3'h4
`define RX_OVERRUN_ERROR 3'h1
`define RX_RECEIVE_NINTH_BIT 3'h0
`define RX_WMASK 8'hF8

// baud_control fields
`define BC_RCIDL 3'h6
`define BC_SCKP 3'h4
`define BC_WMASK 8'h1B

// interrupt enable and flag fields
`define IE_GIE 3'h7
`define IE_PERIPHERAL_IRQ_ENABLE 3'h6
`define IE_RECEIVE_IRQ_ENABLE 3'h5
`define IE_TRANSMIT_IRQ_ENABLE 3'h4
`define IF_RECEIVE_FULL_FLAG 3'h5
`define IF_TRANSMIT_BUFFER_EMPTY_FLAG 3'h4

// reset values
`define RST_BYTE 8'h00

// bits per character
`define BITS_8 4'h8
`define BITS_9 4'h9
`define CNT_ONE 4'h1

`endif

// ### hw/serial_port_pkg.sv
// types shared by the slave serial port files
package serial_port_pkg;

	// one received or held character, ninth bit on top
	typedef struct packed {
		logic ninth;
		logic [7:0] data;
	} char_t;

	// the two synchronised link pins
	typedef struct packed {
		logic ck;
		logic dt;
	} link_pins_t;

	// transmit shift register state, gray along idle, shift, last
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SHIFT = 2'b01,
		TX_LAST = 2'b11
	} tx_state_t;

endpackage

// ### hw/sync_stage.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sync_stage #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule // sync_stage

`default_nettype wire

// ### hw/rx_fifo2.sv
// two-character receive fifo
`timescale 1ns/1ps
`default_nettype none

module rx_fifo2 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire serial_port_pkg::char_t push_data,
	input wire logic pop,
	output serial_port_pkg::char_t head,
	output logic empty,
	output logic full
);

	serial_port_pkg::char_t mem [2];
	logic wr_q;
	logic rd_q;
	logic [1:0] count_q;

	assign empty = (count_q == 2'h0);
	assign full = (count_q == 2'h2);
	assign head = mem[rd_q];

	// storage; a push into a full fifo is dropped, old data kept
	always_ff @(posedge clk) begin
		if (push && !full) begin
			mem[wr_q] <= push_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			count_q <= 2'h0;
		end else if (flush) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push && !full) begin
				wr_q <= ~wr_q;
			end
			if (pop && !empty) begin
				rd_q <= ~rd_q;
			end
			count_q <= count_q + {1'b0, push && !full} - {1'b0, pop && !empty};
		end
	end

endmodule // rx_fifo2

`default_nettype wire

// ### hw/sync_slave_serial_port.sv
// synchronous slave serial port with apb register access
// Function
// - sync-select bit set makes the port synchronous with separate clock line.
// - sync with clock-source-master clear: slave, shift clock comes from outside.
// - both receive enables clear with transmit enable set means transmit mode, either set means receive.
// - port works only with port enable set; clearing it resets shift logic, fifo and overrun, not the registers.
// - a write to an empty transmit path loads the shift register at once.
// - a write while shifting stays held; transmit-empty flag stays clear.
// - after shift-out the held character moves in, then transmit-empty sets.
// - transmit-empty with transmit and peripheral enables raises a wake request.
// - ninth transmit bit is written first and sent as ninth bit.
// - continuous receive stays set, receiver accepts whenever clocks arrive.
// - single-receive enable has no effect on slave reception.
// - receiver runs on external clock alone, also while processor sleeps; here it runs on pclk and samples the synchronised clock pin.
// - a complete character moves from receive shift register into the fifo.
// - completed character with receive and peripheral enables raises a wake-capable request.
// - receive-full flag sets when a character has completed.
// - reading receive data returns the oldest low byte and advances the fifo.
// - overrun clears on clearing continuous receive or the port enable.
// - one bit per clock, changed on leading edge, valid at trailing edge.
// - the clock pin driver is off in slave transmit and receive.
// - fifo holds two; a third sets overrun, keeps data, blocks reception.
// - nine-bit receive shifts nine bits per character.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.svh"

module sync_slave_serial_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	output logic wake_req,
	output logic irq_req
);

	// software registers, stored as whole bytes
	logic [7:0] tx_ctl_q;
	logic [7:0] rx_ctl_q;
	logic [7:0] baud_q;
	logic [7:0] div_low_q;
	logic [7:0] div_high_q;
	logic [7:0] irq_en_q;

	// apb decode
	logic setup;
	logic access;
	logic wr;
	logic hit;
	logic [7:0] rd_byte;
	logic pop_ok_q;

	// mode decode
	logic serial_port_enable;
	logic clock_source_master;
	logic continuous_receive_enable;
	logic single_receive_enable;
	logic slave_on;
	logic rx_mode;
	logic tx_mode;
	logic rx_run;

	// link pins after synchronisation and edge finding
	serial_port_pkg::link_pins_t pins_raw;
	serial_port_pkg::link_pins_t pins_s;
	logic ck_lvl;
	logic ck_prev_q;
	logic lead;
	logic trail;

	// transmit path
	serial_port_pkg::tx_state_t tx_state_q;
	logic [8:0] transmit_shift_reg;
	logic [3:0] tx_cnt_q;
	serial_port_pkg::char_t transmit_holding_reg;
	logic thr_full_q;
	logic dout_q;
	logic tx_wr;
	logic tx_busy;
	logic tx_done;
	logic [3:0] tx_bits;
	logic transmit_buffer_empty_flag;

	// receive path
	logic [8:0] receive_shift_reg;
	logic [8:0] rsr_next;
	logic [3:0] rx_cnt_q;
	logic [3:0] rx_bits;
	logic rx_done;
	logic overrun_error;
	serial_port_pkg::char_t rx_char;
	serial_port_pkg::char_t rx_head;
	logic fifo_empty;
	logic fifo_full;
	logic fifo_push;
	logic fifo_pop;
	logic receive_full_flag;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign pready = 1'b1;

	// address decode; anything else answers with an error
	always_comb begin
		case (paddr)
			`OFS_TX_STATUS, `OFS_RX_STATUS, `OFS_BAUD_CTRL, `OFS_DIV_LOW, `OFS_DIV_HIGH,
			`OFS_TX_DATA, `OFS_RX_DATA, `OFS_IRQ_EN, `OFS_IRQ_FLAG: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	assign pslverr = access && !hit;

	// field decode
	assign serial_port_enable = rx_ctl_q[`RX_SERIAL_PORT_ENABLE];
	assign clock_source_master = tx_ctl_q[`TX_CLOCK_SOURCE_MASTER];
	assign continuous_receive_enable = rx_ctl_q[`RX_CONTINUOUS_RECEIVE_ENABLE];
	assign single_receive_enable = rx_ctl_q[`RX_SINGLE_RECEIVE_ENABLE];
	assign slave_on = serial_port_enable && tx_ctl_q[`TX_SYNC] && !clock_source_master;
	assign rx_mode = single_receive_enable || continuous_receive_enable;
	assign tx_mode = slave_on && !rx_mode && tx_ctl_q[`TX_TRANSMIT_ENABLE];
	// only the continuous enable gates slave reception
	assign rx_run = slave_on && continuous_receive_enable && !overrun_error;

	// clock pin is never driven in slave mode
	assign serial_clock_pin_out = 1'b0;
	assign serial_clock_pin_oe = 1'b0;
	assign serial_data_pin_out = dout_q;
	assign serial_data_pin_oe = tx_mode;

	// register writes; read-only bits are masked off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ctl_q <= `RST_BYTE;
			rx_ctl_q <= `RST_BYTE;
			baud_q <= `RST_BYTE;
			div_low_q <= `RST_BYTE;
			div_high_q <= `RST_BYTE;
			irq_en_q <= `RST_BYTE;
		end else if (wr) begin
			case (paddr)
				`OFS_TX_STATUS: tx_ctl_q <= pwdata[7:0] & `TX_WMASK;
				`OFS_RX_STATUS: rx_ctl_q <= pwdata[7:0] & `RX_WMASK;
				`OFS_BAUD_CTRL: baud_q <= pwdata[7:0] & `BC_WMASK;
				`OFS_DIV_LOW: div_low_q <= pwdata[7:0];
				`OFS_DIV_HIGH: div_high_q <= pwdata[7:0];
				`OFS_IRQ_EN: irq_en_q <= pwdata[7:0];
				default: irq_en_q <= irq_en_q;
			endcase
		end
	end

	// read mux, live status folded into the stored bytes
	always_comb begin
		case (paddr)
			`OFS_TX_STATUS: begin
				rd_byte = tx_ctl_q;
				rd_byte[`TX_TRMT] = !tx_busy;
			end
			`OFS_RX_STATUS: begin
				rd_byte = rx_ctl_q;
				rd_byte[`RX_OVERRUN_ERROR] = overrun_error;
				rd_byte[`RX_RECEIVE_NINTH_BIT] = rx_head.ninth && !fifo_empty;
			end
			`OFS_BAUD_CTRL: begin
				rd_byte = baud_q;
				rd_byte[`BC_RCIDL] = (rx_cnt_q == 4'h0);
			end
			`OFS_DIV_LOW: rd_byte = div_low_q;
			`OFS_DIV_HIGH: rd_byte = div_high_q;
			`OFS_RX_DATA: rd_byte = fifo_empty ? 8'h00 : rx_head.data;
			`OFS_IRQ_EN: rd_byte = irq_en_q;
			`OFS_IRQ_FLAG: begin
				rd_byte = 8'h00;
				rd_byte[`IF_RECEIVE_FULL_FLAG] = receive_full_flag;
				rd_byte[`IF_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
			end
			default: rd_byte = 8'h00;
		endcase
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pop_ok_q <= 1'b0;
		end else if (setup) begin
			prdata <= {24'h00_0000, rd_byte};
			pop_ok_q <= !fifo_empty;
		end
	end

	// pop only what was shown in the setup cycle, so no unseen character is lost
	assign fifo_pop = access && !pwrite && (paddr == `OFS_RX_DATA) && pop_ok_q;

	// pins cross into pclk through two flops each
	assign pins_raw.ck = serial_clock_pin_in;
	assign pins_raw.dt = serial_data_pin_in;

	sync_stage #(
		.WIDTH(2)
	) u_pin_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(pins_raw),
		.q(pins_s)
	);

	// edge finding on the synchronised clock, polarity applied first
	assign ck_lvl = pins_s.ck ^ baud_q[`BC_SCKP];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_prev_q <= 1'b0;
		end else begin
			ck_prev_q <= ck_lvl;
		end
	end
	assign lead = ck_lvl && !ck_prev_q;
	assign trail = !ck_lvl && ck_prev_q;

	// transmit side
	assign tx_wr = wr && (paddr == `OFS_TX_DATA);
	assign tx_busy = (tx_state_q != serial_port_pkg::TX_IDLE);
	assign tx_bits = tx_ctl_q[`TX_TX9] ? `BITS_9 : `BITS_8;
	assign tx_done = (tx_state_q == serial_port_pkg::TX_LAST) && tx_mode && trail;
	assign transmit_buffer_empty_flag = !thr_full_q;

	// shift register, holding register and bit counter; the flops run on pclk and
	// shift on edges of the external clock, found through the pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_q <= serial_port_pkg::TX_IDLE;
			transmit_shift_reg <= 9'h000;
			tx_cnt_q <= 4'h0;
			transmit_holding_reg <= '0;
			thr_full_q <= 1'b0;
			dout_q <= 1'b0;
		end else if (!slave_on) begin
			tx_state_q <= serial_port_pkg::TX_IDLE;
			tx_cnt_q <= 4'h0;
			thr_full_q <= 1'b0;
			dout_q <= 1'b0;
		end else begin
			// bit goes out on the leading edge and holds through the trailing one
			if (tx_mode && lead && tx_busy) begin
				dout_q <= transmit_shift_reg[0];
				transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
			end
			if (tx_done) begin
				tx_cnt_q <= 4'h0;
				if (thr_full_q) begin
					transmit_shift_reg <= transmit_holding_reg;
					tx_state_q <= serial_port_pkg::TX_SHIFT;
					thr_full_q <= tx_wr;
					if (tx_wr) begin
						transmit_holding_reg <= {tx_ctl_q[`TX_TRANSMIT_NINTH_BIT], pwdata[7:0]};
					end
				end else if (tx_wr) begin
					transmit_shift_reg <= {tx_ctl_q[`TX_TRANSMIT_NINTH_BIT], pwdata[7:0]};
					tx_state_q <= serial_port_pkg::TX_SHIFT;
				end else begin
					tx_state_q <= serial_port_pkg::TX_IDLE;
				end
			end else begin
				if (tx_mode && trail && tx_busy) begin
					tx_cnt_q <= tx_cnt_q + `CNT_ONE;
					if (tx_cnt_q == tx_bits - `CNT_ONE - `CNT_ONE) begin
						tx_state_q <= serial_port_pkg::TX_LAST;
					end
				end
				if (tx_wr) begin
					if (!tx_busy) begin
						transmit_shift_reg <= {tx_ctl_q[`TX_TRANSMIT_NINTH_BIT], pwdata[7:0]};
						tx_state_q <= serial_port_pkg::TX_SHIFT;
						tx_cnt_q <= 4'h0;
					end else begin
						transmit_holding_reg <= {tx_ctl_q[`TX_TRANSMIT_NINTH_BIT], pwdata[7:0]};
						thr_full_q <= 1'b1;
					end
				end
			end
		end
	end

	// receive side: sample on the trailing edge, lsb first
	assign rx_bits = rx_ctl_q[`RX_RX9] ? `BITS_9 : `BITS_8;
	assign rsr_next = {pins_s.dt, receive_shift_reg[8:1]};
	assign rx_done = rx_run && trail && (rx_cnt_q == rx_bits - `CNT_ONE);
	assign rx_char.ninth = rx_ctl_q[`RX_RX9] ? rsr_next[8] : 1'b0;
	assign rx_char.data = rx_ctl_q[`RX_RX9] ? rsr_next[7:0] : rsr_next[8:1];
	assign fifo_push = rx_done && !fifo_full;

	// shift register and counter; clearing continuous receive drops a partial character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_shift_reg <= 9'h000;
			rx_cnt_q <= 4'h0;
		end else if (!rx_run) begin
			rx_cnt_q <= 4'h0;
		end else if (trail) begin
			receive_shift_reg <= rsr_next;
			rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + `CNT_ONE;
		end
	end

	// overrun: set by a full third character, cleared with the enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_error <= 1'b0;
		end else if (!slave_on || !continuous_receive_enable) begin
			overrun_error <= 1'b0;
		end else if (rx_done && fifo_full) begin
			overrun_error <= 1'b1;
		end
	end

	rx_fifo2 u_rx_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.flush(!slave_on),
		.push(fifo_push),
		.push_data(rx_char),
		.pop(fifo_pop),
		.head(rx_head),
		.empty(fifo_empty),
		.full(fifo_full)
	);

	// receive-full follows unread characters, so it needs no clear of its own
	assign receive_full_flag = !fifo_empty;

	// wake and interrupt requests; gie gates only the interrupt, not the wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_req <= 1'b0;
			irq_req <= 1'b0;
		end else begin
			wake_req <= irq_en_q[`IE_PERIPHERAL_IRQ_ENABLE] && ((transmit_buffer_empty_flag && irq_en_q[`IE_TRANSMIT_IRQ_ENABLE]) ||
				(receive_full_flag && irq_en_q[`IE_RECEIVE_IRQ_ENABLE]));
			irq_req <= irq_en_q[`IE_GIE] && irq_en_q[`IE_PERIPHERAL_IRQ_ENABLE] &&
				((transmit_buffer_empty_flag && irq_en_q[`IE_TRANSMIT_IRQ_ENABLE]) || (receive_full_flag && irq_en_q[`IE_RECEIVE_IRQ_ENABLE]));
		end
	end

endmodule // sync_slave_serial_port

`default_nettype wire

// ### tb/serial_port_checker_assertions.sv
// port-level checker of the slave serial port
`timescale 1ns/1ps
`default_nettype none

module serial_port_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_clock_pin_in,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe,
	input wire logic serial_data_pin_in,
	input wire logic serial_data_pin_out,
	input wire logic serial_data_pin_oe,
	input wire logic wake_req,
	input wire logic irq_req
);
	logic ck_prev_q;
	logic [7:0] edge_age_q;

	// cycles since any raw link clock edge, saturating so it never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_prev_q <= 1'b0;
			edge_age_q <= 8'hFF;
		end else begin
			ck_prev_q <= serial_clock_pin_in;
			if (serial_clock_pin_in != ck_prev_q) edge_age_q <= 8'h00;
			else if (edge_age_q != 8'hFF) edge_age_q <= edge_age_q + 8'h01;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ck_idle; !serial_clock_pin_oe && !serial_clock_pin_out; endproperty
	a_ck_idle: assert property (p_ck_idle) else $error("clock pin driven by slave");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access without ready");
	property p_slverr; pslverr |-> psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'b00); endproperty
	a_slverr: assert property (p_slverr) else $error("error response on a mapped access");
	property p_rdata_hi; prdata[31:8] == 24'h000000; endproperty
	a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data not zero");
	property p_irq_wake; irq_req |-> wake_req; endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("interrupt without wake request");
	property p_oe_cause; $changed(serial_data_pin_oe) |-> $past(psel) && $past(penable) && $past(pwrite); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("data driver changed without a write");
	// bit changes only follow the link clock; the register-write case is left out
	property p_data_edge;
		$changed(serial_data_pin_out) && serial_data_pin_oe && !$past(psel) && !$past(psel, 2) |-> edge_age_q < 8'h07;
	endproperty
	a_data_edge: assert property (p_data_edge) else $error("data changed away from a clock edge");
	property p_reset_quiet; !$past(presetn) |-> !wake_req && !irq_req && !serial_data_pin_oe; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active right after reset");

	c_wake: cover property ($rose(wake_req));
	c_irq: cover property ($rose(irq_req));
	c_slverr: cover property (pslverr);
	c_tx_bit: cover property (serial_data_pin_oe && $fell(serial_clock_pin_in));
endmodule // serial_port_checker

bind sync_slave_serial_port serial_port_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe,
	.serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe, .wake_req, .irq_req);

`default_nettype wire

// ### tb/link_master.sv
// behavioural external master that clocks the slave link
`timescale 1ns/1ps
`default_nettype none

module link_master (
	output var logic ck,
	output var logic dt,
	input wire logic dt_line
);
	// clock stands low between frames, as an idle master would leave it
	initial begin
		ck = 1'b0;
		dt = 1'b1;
	end

	// one bit per clock, lsb first, ninth bit last
	task automatic frame(input int nbits, input logic [8:0] word, output logic [8:0] got);
		got = 9'h000;
		#7;
		for (int i = 0; i < nbits; i++) begin
			#160 ck = 1'b1;
			dt = word[i];
			#160 ck = 1'b0;
			got[i] = dt_line;
		end
		#160 dt = ~dt; // released line must not look held
	endtask
endmodule // link_master

`default_nettype wire

// ### tb/tb_sync_slave_serial_port.sv
// self-checking bench for the slave serial port
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.svh"

module tb_sync_slave_serial_port;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [31:0] exp;
		logic err;
	} row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic ck_line, master_dt, ck_out, ck_oe, dt_out, dt_oe, wake_req, irq_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [8:0] got;
	wire logic dt_line;
	int n_fail, n_compared;
	row_t rows [5];

	// shared data wire: slave when it drives, master otherwise
	assign dt_line = dt_oe ? dt_out : master_dt;

	sync_slave_serial_port dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .serial_clock_pin_in(ck_line), .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe),
		.serial_data_pin_in(dt_line), .serial_data_pin_out(dt_out), .serial_data_pin_oe(dt_oe), .wake_req, .irq_req);
	link_master partner_u (.ck(ck_line), .dt(master_dt), .dt_line);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: value %h, expected %h", $time, g, e);
		end
	endtask

	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: flag %b, expected %b", $time, g, e);
		end
	endtask

	// one apb transfer; held until ready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk32(rd, e);
	endtask

	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog, far beyond the nine frames of the run
	initial begin
		#2000000;
		n_fail++;
		results;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		n_fail = 0;
		n_compared = 0;
		rows[0] = '{`OFS_DIV_LOW, 8'hFF, 32'h000000FF, 1'b0};
		rows[1] = '{`OFS_DIV_HIGH, 8'h5A, 32'h0000005A, 1'b0};
		rows[2] = '{`OFS_IRQ_EN, 8'hF0, 32'h000000F0, 1'b0};
		rows[3] = '{`OFS_BAUD_CTRL, 8'hFF, 32'h0000005B, 1'b0};
		rows[4] = '{8'h24, 8'h12, 32'h00000000, 1'b1};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].addr, rows[i].wdata);
			rd_chk(rows[i].addr, rows[i].exp);
			chk1(rd_err, rows[i].err);
		end
		$display("test registers done");
		// mid-run reset clears stored values
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`OFS_DIV_LOW, 32'h00000000);
		rd_chk(`OFS_IRQ_EN, 32'h00000000);
		$display("test reset done");
		// transmit: one char shifting, one held; master clocking keeps the data pin quiet
		apb(1'b1, `OFS_RX_STATUS, 8'h80);
		apb(1'b1, `OFS_TX_STATUS, 8'hB0);
		@(posedge pclk);
		chk1(dt_oe, 1'b0);
		apb(1'b1, `OFS_TX_STATUS, 8'h10);
		apb(1'b1, `OFS_TX_STATUS, 8'h30);
		apb(1'b1, `OFS_IRQ_EN, 8'h50);
		chk1(dt_oe, 1'b1);
		chk1(ck_oe, 1'b0);
		apb(1'b1, `OFS_TX_DATA, 8'hA5);
		apb(1'b1, `OFS_TX_DATA, 8'h3C);
		rd_chk(`OFS_IRQ_FLAG, 32'h00000000);
		chk1(wake_req, 1'b0);
		partner_u.frame(8, 9'h000, got);
		chk32({23'h000000, got}, 32'h000000A5);
		repeat (6) @(posedge pclk);
		rd_chk(`OFS_IRQ_FLAG, 32'h00000010);
		chk1(wake_req, 1'b1);
		chk1(irq_req, 1'b0);
		partner_u.frame(8, 9'h000, got);
		chk32({23'h000000, got}, 32'h0000003C);
		apb(1'b1, `OFS_TX_STATUS, 8'h71);
		apb(1'b1, `OFS_TX_DATA, 8'h5A);
		partner_u.frame(9, 9'h000, got);
		chk32({23'h000000, got}, 32'h0000015A);
		$display("test transmit done");
		// receive: transmit enable left set, so only the receive enables turn the driver off
		apb(1'b1, `OFS_IRQ_EN, 8'hE0);
		apb(1'b1, `OFS_TX_STATUS, 8'h30);
		apb(1'b1, `OFS_RX_STATUS, 8'hB0);
		@(posedge pclk);
		chk1(dt_oe, 1'b0);
		chk1(wake_req, 1'b0);
		partner_u.frame(8, 9'h0C3, got);
		repeat (6) @(posedge pclk);
		rd_chk(`OFS_IRQ_FLAG, 32'h00000030);
		chk1(irq_req, 1'b1);
		chk1(wake_req, 1'b1);
		partner_u.frame(8, 9'h081, got);
		partner_u.frame(8, 9'h07E, got);
		repeat (6) @(posedge pclk);
		rd_chk(`OFS_RX_STATUS, 32'h000000B2);
		rd_chk(`OFS_RX_DATA, 32'h000000C3);
		rd_chk(`OFS_RX_DATA, 32'h00000081);
		rd_chk(`OFS_RX_DATA, 32'h00000000);
		apb(1'b1, `OFS_RX_STATUS, 8'hA0);
		rd_chk(`OFS_RX_STATUS, 32'h000000A0);
		// single receive alone: still receive mode, but nothing is taken in
		chk1(dt_oe, 1'b0);
		partner_u.frame(8, 9'h0F0, got);
		repeat (6) @(posedge pclk);
		rd_chk(`OFS_IRQ_FLAG, 32'h00000010);
		apb(1'b1, `OFS_RX_STATUS, 8'hD0);
		partner_u.frame(9, 9'h12D, got);
		repeat (6) @(posedge pclk);
		rd_chk(`OFS_RX_STATUS, 32'h000000D1);
		rd_chk(`OFS_RX_DATA, 32'h0000002D);
		// cut frame: eight of nine bits leave the receiver busy until the port is disabled
		partner_u.frame(8, 9'h055, got);
		repeat (6) @(posedge pclk);
		rd_chk(`OFS_BAUD_CTRL, 32'h00000000);
		apb(1'b1, `OFS_RX_STATUS, 8'h00);
		rd_chk(`OFS_IRQ_FLAG, 32'h00000010);
		rd_chk(`OFS_BAUD_CTRL, 32'h00000040);
		$display("test receive done");
		results;
	end
endmodule // tb_sync_slave_serial_port

`default_nettype wire
